/* rtl/analog_align_comparator_bytes.v */
`timescale 1ns/1ps
`default_nettype none
`include "analog_align_comparator_bytes_defines.vh"
module analog_align_comparator_bytes #(
  parameter NUM_ANA = 8,
  parameter NUM_DOUT = 4
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output wire [31:0] rd_data,
  input wire sample_strobe,
  input wire [NUM_ANA*16-1:0] ana_raw,
  output wire [NUM_ANA*16-1:0] ana_aligned,
  output wire [7:0] comp_byte1,
  output wire [7:0] comp_byte2,
  output wire [NUM_DOUT*8-1:0] dig_out,
  output wire [NUM_DOUT-1:0] dig_out_act,
  output wire eval_done
);
  // reset release through two flops
  // every other flop sees only the synchronised copy, never resetn itself
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // configuration state
  reg [31:0] type1_ff;
  reg [31:0] type2_ff;
  reg [15:0] res_ff;
  reg [3:0] src1_ff [0:7];
  reg [3:0] src2_ff [0:7];
  reg [15:0] thr1_ff [0:7];
  reg [15:0] thr2_ff [0:7];

  // evaluation state
  reg eval_ff;
  reg [15:0] count_ff;
  reg [7:0] comp1_ff;
  reg [7:0] comp2_ff;
  reg [NUM_DOUT*8-1:0] dout_ff;
  reg [NUM_DOUT-1:0] dout_act_ff;
  reg [31:0] rd_data_ff;

  wire [8*4-1:0] src1_flat;
  wire [8*4-1:0] src2_flat;
  wire [8*16-1:0] thr1_flat;
  wire [8*16-1:0] thr2_flat;
  wire [7:0] res1;
  wire [7:0] res2;
  wire [7:0] out1;
  wire [7:0] out2;
  wire [NUM_ANA*2-1:0] res_sel;
  wire [4:0] page;
  wire [2:0] idx;

  assign page = addr[7:3];
  assign idx = addr[2:0];

  // one decode per register; read-only offsets never match a write
  wire wr_type1;
  wire wr_type2;
  wire wr_res;

  assign wr_type1 = wr_en && (addr == `OFF_TYPE1);
  assign wr_type2 = wr_en && (addr == `OFF_TYPE2);
  assign wr_res = wr_en && (addr == `OFF_RES);

  // single registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      type1_ff <= `TYPE_RESET;
      type2_ff <= `TYPE_RESET;
      res_ff <= `RES_RESET;
    end else begin
      if (wr_type1) begin
        type1_ff <= wr_data;
      end
      if (wr_type2) begin
        type2_ff <= wr_data;
      end
      if (wr_res) begin
        res_ff <= wr_data[15:0];
      end
    end
  end

  // per-bit tables, one entry per comparator bit
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_tab
      localparam integer IDX = i;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          src1_ff[i] <= `SRC_RESET;
          src2_ff[i] <= `SRC_RESET;
          thr1_ff[i] <= `THR_RESET;
          thr2_ff[i] <= `THR_RESET;
        end else if (wr_en && idx == IDX) begin
          if (page == `PAGE_SRC1) begin
            src1_ff[i] <= wr_data[3:0]; // RULE8
          end
          if (page == `PAGE_SRC2) begin
            src2_ff[i] <= wr_data[3:0]; // RULE8
          end
          if (page == `PAGE_THR1) begin
            thr1_ff[i] <= wr_data[15:0]; // RULE13
          end
          if (page == `PAGE_THR2) begin
            thr2_ff[i] <= wr_data[15:0]; // RULE13
          end
        end
      end
      assign src1_flat[i*4 +: 4] = src1_ff[i];
      assign src2_flat[i*4 +: 4] = src2_ff[i];
      assign thr1_flat[i*16 +: 16] = thr1_ff[i];
      assign thr2_flat[i*16 +: 16] = thr2_ff[i];
    end
  endgenerate

  // resolution code per channel, two bits each; channels past eight stay 16-bit
  genvar r;
  generate
    for (r = 0; r < NUM_ANA; r = r + 1) begin : g_res
      if (r < 8) begin : g_cfg
        assign res_sel[r*2 +: 2] = res_ff[r*2 +: 2];
      end else begin : g_fix
        assign res_sel[r*2 +: 2] = `RES_16;
      end
    end
  endgenerate

  sample_align #(
    .NUM_ANA(NUM_ANA)
  ) u_align (
    .clk(clk),
    .rst_n(rst_n),
    .strobe(sample_strobe),
    .raw(ana_raw),
    .res_sel(res_sel),
    .aligned(ana_aligned)
  );

  // both bytes share the aligned bus; one channel may feed any number of bits
  comparator_byte #(
    .NUM_ANA(NUM_ANA)
  ) u_cmp1 (
    .aligned(ana_aligned),
    .type_word(type1_ff),
    .src_table(src1_flat),
    .thr_table(thr1_flat),
    .result(res1),
    .out_byte(out1)
  );

  comparator_byte #(
    .NUM_ANA(NUM_ANA)
  ) u_cmp2 (
    .aligned(ana_aligned),
    .type_word(type2_ff),
    .src_table(src2_flat),
    .thr_table(thr2_flat),
    .result(res2),
    .out_byte(out2)
  );

  // mirror target selection; byte 2 wins when both name the same output
  wire [7:0] sel1;
  wire [7:0] sel2;
  wire [NUM_DOUT*8-1:0] nxt_dout;
  wire [NUM_DOUT-1:0] nxt_dout_act;

  assign sel1 = type1_ff[`TYPE_SEL_LSB +: 8];
  assign sel2 = type2_ff[`TYPE_SEL_LSB +: 8];

  genvar k;
  generate
    for (k = 0; k < NUM_DOUT; k = k + 1) begin : g_dout
      wire hit1;
      wire hit2;
      reg [7:0] byte_mux;
      assign hit1 = (sel1 == k + 1);
      assign hit2 = (sel2 == k + 1);
      // output number 0 names no byte, so a cleared select frees the byte
      always @* begin
        if (hit2) begin
          byte_mux = out2;
        end else if (hit1) begin
          byte_mux = out1;
        end else begin
          byte_mux = 8'h00;
        end
      end
      assign nxt_dout[k*8 +: 8] = byte_mux; // RULE11
      assign nxt_dout_act[k] = hit1 | hit2;
    end
  endgenerate

  // evaluation runs one cycle after the samples are aligned
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eval_ff <= 1'b0;
    end else begin
      eval_ff <= sample_strobe;
    end
  end

  // results and mirrored bytes move on the same edge so they never disagree
  // the evaluation count wraps silently; it only shows that evaluations happen
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp1_ff <= 8'h00;
      comp2_ff <= 8'h00;
      dout_ff <= {(NUM_DOUT*8){1'b0}};
      dout_act_ff <= {NUM_DOUT{1'b0}};
      count_ff <= 16'h0000;
    end else if (eval_ff) begin
      comp1_ff <= res1; // RULE5 RULE16
      comp2_ff <= res2; // RULE5 RULE16
      dout_ff <= nxt_dout; // RULE16
      dout_act_ff <= nxt_dout_act;
      count_ff <= count_ff + 16'h0001;
    end
  end

  // read path; unmapped addresses read zero
  reg [31:0] nxt_rd;
  wire [15:0] align_word;
  wire [15:0] chan_word [0:7];

  // eight read slots; idx cannot reach channels past the eighth
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : g_pick
      if (m < NUM_ANA) begin : g_live
        assign chan_word[m] = ana_aligned[m*16 +: 16];
      end else begin : g_none
        assign chan_word[m] = 16'h0000;
      end
    end
  endgenerate
  assign align_word = chan_word[idx];

  always @* begin
    nxt_rd = 32'h00000000;
    case (page)
      `PAGE_SRC1: nxt_rd = {28'h0000000, src1_ff[idx]};
      `PAGE_SRC2: nxt_rd = {28'h0000000, src2_ff[idx]};
      `PAGE_THR1: nxt_rd = {16'h0000, thr1_ff[idx]};
      `PAGE_THR2: nxt_rd = {16'h0000, thr2_ff[idx]};
      `PAGE_ALIGN: nxt_rd = {16'h0000, align_word};
      `PAGE_BIT1: nxt_rd = {31'h0, comp1_ff[idx]}; // RULE7 RULE15
      `PAGE_BIT2: nxt_rd = {31'h0, comp2_ff[idx]}; // RULE7 RULE15
      default: begin
        case (addr)
          `OFF_TYPE1: nxt_rd = type1_ff;
          `OFF_TYPE2: nxt_rd = type2_ff;
          `OFF_RES: nxt_rd = {16'h0000, res_ff};
          `OFF_COUNT: nxt_rd = {16'h0000, count_ff};
          `OFF_COMP1: nxt_rd = {24'h000000, comp1_ff}; // RULE14
          `OFF_COMP2: nxt_rd = {24'h000000, comp2_ff}; // RULE14
          `OFF_DOUT: nxt_rd = {{(32-8){1'b0}}, dout_ff[7:0]};
          default: nxt_rd = 32'h00000000;
        endcase
      end
    endcase
  end

  // data holds only in the cycle after the read strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 32'h00000000;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd;
    end else begin
      rd_data_ff <= 32'h00000000;
    end
  end

  // every output leaves straight from a flop, nothing combinational escapes
  assign rd_data = rd_data_ff;
  assign comp_byte1 = comp1_ff;
  assign comp_byte2 = comp2_ff;
  assign dig_out = dout_ff;
  assign dig_out_act = dout_act_ff;
  assign eval_done = eval_ff;
endmodule // analog_align_comparator_bytes
`default_nettype wire

/* rtl/analog_align_comparator_bytes_defines.vh */
// Functional notes
// RULE1 - every analog value appears as a 16-bit two's-complement word, sign in bit 15.
// RULE2 - narrower samples sit left-justified from bit 14, unused low bits zero.
// RULE3 - a 14-bit sample forces bits 1..0 to zero.
// RULE4 - a 12-bit sample forces bits 3..0 to zero.
// RULE5 - two comparator bytes of eight result bits each exist.
// RULE6 - each result bit compares its assigned analog input with its threshold.
// RULE7 - inputs 1..8 are byte 1 bits n-1; inputs 9..16 are byte 2 bits n-9.
// RULE8 - each bit picks its analog input from a per-byte table; sharing allowed.
// RULE9 - type bit 1 sets result at value >= threshold; 0 clears it at value <= threshold.
// RULE10 - otherwise the complementary result is driven.
// RULE11 - type word bits 23..16 name a digital output byte receiving the whole byte.
// RULE12 - type word bits 31..24: one passes a bit unchanged, zero inverts it.
// RULE13 - every bit of every byte has its own threshold.
// RULE14 - comparator bytes read as input byte addresses 128 and 129.
// RULE15 - each single comparator result can be read directly.
// RULE16 - all bits re-evaluated each sampling cycle; mirrored outputs update alongside.
`ifndef ANALOG_ALIGN_COMPARATOR_BYTES_DEFINES_VH
`define ANALOG_ALIGN_COMPARATOR_BYTES_DEFINES_VH

`define WORD_W 16
`define SIGN_BIT 15
`define RES_16 2'h0
`define RES_14 2'h1
`define RES_12 2'h2

`define OFF_TYPE1 8'h00
`define OFF_TYPE2 8'h01
`define OFF_RES 8'h02
`define OFF_COUNT 8'h03
`define OFF_COMP1 8'h80
`define OFF_COMP2 8'h81
`define OFF_DOUT 8'h82
`define PAGE_SRC1 5'h02
`define PAGE_SRC2 5'h03
`define PAGE_THR1 5'h04
`define PAGE_THR2 5'h05
`define PAGE_ALIGN 5'h08
`define PAGE_BIT1 5'h12
`define PAGE_BIT2 5'h13

`define TYPE_MASK_LSB 0
`define TYPE_SEL_LSB 16
`define TYPE_POL_LSB 24
`define TYPE_RESET 32'hff000000
`define SRC_RESET 4'h0
`define THR_RESET 16'h0000
`define RES_RESET 16'h0000

`endif

/* rtl/sample_align.v */
`timescale 1ns/1ps
`default_nettype none
`include "analog_align_comparator_bytes_defines.vh"
module sample_align #(
  parameter NUM_ANA = 8
) (
  input wire clk,
  input wire rst_n,
  input wire strobe,
  input wire [NUM_ANA*16-1:0] raw,
  input wire [NUM_ANA*2-1:0] res_sel,
  output wire [NUM_ANA*16-1:0] aligned
);
  genvar c;
  generate
    for (c = 0; c < NUM_ANA; c = c + 1) begin : g_ch
      reg [15:0] word_ff;
      reg [15:0] nxt_word;
      wire [15:0] r;
      wire [1:0] sel;
      assign r = raw[c*16 +: 16];
      assign sel = res_sel[c*2 +: 2];
      // raw arrives right-justified, sign-extended or not: only the low res bits count
      always @* begin
        case (sel)
          `RES_14: nxt_word = {r[13:0], 2'h0}; // RULE2 RULE3
          `RES_12: nxt_word = {r[11:0], 4'h0}; // RULE2 RULE4
          default: nxt_word = r; // RULE1
        endcase
      end
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          word_ff <= 16'h0000;
        end else if (strobe) begin
          word_ff <= nxt_word;
        end
      end
      assign aligned[c*16 +: 16] = word_ff;
    end
  endgenerate
endmodule // sample_align
`default_nettype wire

/* rtl/comparator_byte.v */
`timescale 1ns/1ps
`default_nettype none
`include "analog_align_comparator_bytes_defines.vh"
module comparator_byte #(
  parameter NUM_ANA = 8
) (
  input wire [NUM_ANA*16-1:0] aligned,
  input wire [31:0] type_word,
  input wire [8*4-1:0] src_table,
  input wire [8*16-1:0] thr_table,
  output wire [7:0] result,
  output wire [7:0] out_byte
);
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      wire [3:0] src;
      wire signed [15:0] thr;
      wire signed [15:0] val;
      wire above_eq;
      wire above;
      assign src = src_table[b*4 +: 4];
      assign thr = thr_table[b*16 +: 16]; // RULE13
      // unassigned or out-of-range source reads as zero volts
      assign val = (src == 4'h0 || src > NUM_ANA) ? 16'sh0000 :
        aligned[(src-4'h1)*16 +: 16]; // RULE8
      assign above_eq = (val >= thr); // RULE6
      assign above = (val > thr);
      assign result[b] = type_word[`TYPE_MASK_LSB + b] ? above_eq : above; // RULE9 RULE10
      assign out_byte[b] = type_word[`TYPE_POL_LSB + b] ? result[b] : ~result[b]; // RULE12
    end
  endgenerate
endmodule // comparator_byte
`default_nettype wire

/* dv/ana_source.sv */
`timescale 1ns/1ps
`default_nettype none
module ana_source #(
  parameter int NUM_ANA = 8
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [NUM_ANA*16-1:0] vals,
  output logic sample_strobe,
  output logic [NUM_ANA*16-1:0] ana_raw
);
  initial sample_strobe = 1'b0;
  initial ana_raw = '0;
  // lines toggle between conversions so a capture off the strobe shows up
  always @(posedge clk) begin
    sample_strobe <= go;
    ana_raw <= go ? vals : ~ana_raw;
  end
endmodule // ana_source
`default_nettype wire

/* dv/analog_align_comparator_bytes_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_align_comparator_bytes_checker #(
  parameter NUM_ANA = 8,
  parameter NUM_DOUT = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic sample_strobe,
  input wire logic [NUM_ANA*16-1:0] ana_raw,
  input wire logic [NUM_ANA*16-1:0] ana_aligned,
  input wire logic [7:0] comp_byte1,
  input wire logic [7:0] comp_byte2,
  input wire logic [NUM_DOUT*8-1:0] dig_out,
  input wire logic [NUM_DOUT-1:0] dig_out_act,
  input wire logic eval_done
);
  default clocking clk_cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] cb1_q, cb2_q, ad_q;
  logic [15:0] raw_q;
  logic [NUM_DOUT*8-1:0] act_mask;
  always @(posedge clk) begin
    cb1_q <= comp_byte1;
    cb2_q <= comp_byte2;
    ad_q <= addr;
    if (sample_strobe) raw_q <= ana_raw[15:0];
  end
  always_comb
    for (int k = 0; k < NUM_DOUT; k++) act_mask[k*8+:8] = {8{dig_out_act[k]}};
  done_after_strobe_a: assert property (sample_strobe |=> eval_done)
    else $error("eval_done missing after strobe");
  done_needs_strobe_a: assert property (eval_done |-> $past(sample_strobe))
    else $error("eval_done without strobe");
  align_form_a: assert property (eval_done |-> ana_aligned[15:0] == raw_q ||
    ana_aligned[15:0] == {raw_q[13:0], 2'h0} || ana_aligned[15:0] == {raw_q[11:0], 4'h0})
    else $error("aligned word not left-justified");
  comp_hold_a: assert property ($changed(comp_byte1) || $changed(comp_byte2)
    |-> $past(eval_done)) else $error("comparator byte changed off evaluation");
  out_hold_a: assert property ($changed(dig_out) |-> $past(eval_done))
    else $error("output byte changed off evaluation");
  read_byte1_a: assert property (rd_en && addr == 8'h80 |=> rd_data == {24'h0, cb1_q})
    else $error("byte 1 read wrong");
  read_byte2_a: assert property (rd_en && addr == 8'h81 |=> rd_data == {24'h0, cb2_q})
    else $error("byte 2 read wrong");
  read_bit_a: assert property (rd_en && addr[7:4] == 4'h9 |=> rd_data[31:1] == 0 &&
    rd_data[0] == (ad_q[3] ? cb2_q[ad_q[2:0]] : cb1_q[ad_q[2:0]]))
    else $error("single bit read wrong");
  read_idle_a: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data outside read cycle");
  unsel_zero_a: assert property ((dig_out & ~act_mask) == 0)
    else $error("unselected output byte driven");
  eval_c: cover property (eval_done);
  mirror_c: cover property (eval_done ##1 dig_out_act != 0);
  bit_read_c: cover property (rd_en && addr == 8'h90);
endmodule // analog_align_comparator_bytes_checker
bind analog_align_comparator_bytes analog_align_comparator_bytes_checker #(
  .NUM_ANA(NUM_ANA), .NUM_DOUT(NUM_DOUT)) chk_i (.clk, .resetn, .addr, .rd_en, .rd_data,
  .sample_strobe, .ana_raw, .ana_aligned, .comp_byte1, .comp_byte2, .dig_out,
  .dig_out_act, .eval_done);
`default_nettype wire

/* dv/test_analog_align_comparator_bytes.sv */
`timescale 1ns/1ps
`default_nettype none
module test_analog_align_comparator_bytes;
  logic clk = 0, resetn = 0, wr_en = 0, rd_en = 0, go = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, dig_out;
  logic [127:0] vals = 128'h0, ana_raw, ana_aligned;
  logic [3:0] dig_out_act;
  logic [7:0] comp_byte1, comp_byte2, e1, e2;
  logic sample_strobe, eval_done;
  logic [15:0] raw [4] = '{16'h8000, 16'hde66, 16'ha7ff, 16'h72d1};
  logic [15:0] th1 [8] = '{16'h8000, 16'h8000, 16'h7999, 16'h7997,
                           16'h7ff0, 16'h7ff0, 16'h0000, 16'hcb43};
  logic [15:0] a [4];
  int n_mismatch = 0, num_checks = 0, b;
  initial forever #25 clk = ~clk;
  analog_align_comparator_bytes uut (.clk, .resetn, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .sample_strobe, .ana_raw, .ana_aligned, .comp_byte1, .comp_byte2,
    .dig_out, .dig_out_act, .eval_done);
  ana_source src_m (.clk, .go, .vals, .sample_strobe, .ana_raw);
  function logic [15:0] al(input logic [15:0] r, input logic [1:0] s);
    al = s == 2'h1 ? {r[13:0], 2'h0} : s == 2'h2 ? {r[11:0], 4'h0} : r;
  endfunction
  function logic cmp(input logic [15:0] v, t, input logic ge);
    cmp = ge ? $signed(v) >= $signed(t) : $signed(v) > $signed(t);
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, x);
    num_checks++;
    if (g !== x) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      n_mismatch++;
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] x);
    @(posedge clk);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, x);
  endtask
  task smp;
    int i;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 10 && eval_done !== 1'b1; i++) @(negedge clk);
    if (i == 10) begin
      n_mismatch++;
      conclude;
    end
    @(negedge clk);
  endtask
  initial begin
    for (b = 0; b < 4; b++) vals[b*16+:16] = raw[b];
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'hff000000);
    rd(8'h01, 32'hff000000);
    rd(8'h02, 32'h0);
    rd(8'h7f, 32'h0);
    $display("test reset done");
    // ch0 16 bit, ch1 14 bit, ch2 12 bit, ch3 14 bit
    wr(8'h02, 32'h64);
    smp;
    for (b = 0; b < 4; b++) begin
      a[b] = al(raw[b], 2'(32'h64 >> 2 * b));
      chk({16'h0, ana_aligned[b*16+:16]}, {16'h0, a[b]});
    end
    $display("test align done");
    wr(8'h00, 32'ha5010055);
    wr(8'h01, 32'h0f0200f0);
    for (b = 0; b < 8; b++) begin
      wr(8'h10 + 8'(b), b / 2 + 1);
      wr(8'h18 + 8'(b), 32'h2);
      wr(8'h20 + 8'(b), {16'h0, th1[b]});
      wr(8'h28 + 8'(b), 32'h7995 + b);
      e1[b] = cmp(a[b/2], th1[b], b % 2 == 0);
      e2[b] = cmp(a[1], 16'h7995 + 16'(b), b > 3);
    end
    chk(comp_byte1, 32'h0);
    smp;
    chk(comp_byte1, e1);
    chk(comp_byte2, e2);
    rd(8'h80, e1);
    rd(8'h81, e2);
    rd(8'h82, {24'h0, e1 ^ ~8'ha5});
    chk(dig_out, {16'h0, e2 ^ ~8'h0f, e1 ^ ~8'ha5});
    chk(dig_out_act, 4'h3);
    for (b = 0; b < 16; b++) rd(8'h90 + 8'(b), b < 8 ? e1[b] : e2[b-8]);
    $display("test compare done");
    wr(8'h00, 32'ha5000055);
    vals[15:0] <= 16'h7fff;
    a[0] = 16'h7fff;
    for (b = 0; b < 8; b++) e1[b] = cmp(a[b/2], th1[b], b % 2 == 0);
    smp;
    chk(comp_byte1, e1);
    chk(dig_out, {16'h0, e2 ^ ~8'h0f, 8'h0});
    chk(dig_out_act, 4'h2);
    rd(8'h03, 32'h3);
    rd(8'h43, {16'h0, a[3]});
    rd(8'h13, 32'h2);
    rd(8'h2f, 32'h799c);
    $display("test update done");
    conclude;
  end
endmodule // test_analog_align_comparator_bytes
`default_nettype wire
